/* File: cfewl_top.sv */
// Function event, mask, present-state and force-event registers on APB
//
// Design decision made here: the APB slave port.
`include "cfewl_defs.svh"
module cfewl_top
  import cfewl_pkg::*;
#(
  parameter int ISR_W = `CFEWL_ISR_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] third_configuration_register,
  input wire logic [ISR_W-1:0] interrupt_status_register,
  input wire logic pme_status,
  input wire logic interface_powered,
  output logic int_n,
  output logic cstschg
);
  typedef struct packed {
    cfewl_mask_t mask;
    logic general_wake_flag_prev;
  } cfewl_mask_state_t;
  typedef struct packed {
    cfewl_apb_rsp_t rsp;
    logic int_n;
    logic cstschg;
  } cfewl_state_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  cfewl_state_t st;
  cfewl_state_t next_st;
  cfewl_mask_state_t mst;
  cfewl_mask_state_t next_mst;
  cfewl_flags_t ev;
  cfewl_flags_t ps;
  logic regs_on;
  logic wr;
  logic rd;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic [31:0] rdata;

  assign regs_on = third_configuration_register[`CFEWL_CFG3_CARD_EN]
                 & third_configuration_register[`CFEWL_CFG3_FUNC_EN];
  assign wr = psel & penable & pwrite & regs_on;
  assign rd = psel & ~penable & ~pwrite;
  assign ps.function_interrupt_flag = |interrupt_status_register;
  assign ps.general_wake_flag = pme_status;

  // Lane 1 carries bit 15, lane 0 carries bit 4
  assign ev_set[1] = wr & pstrb[1] & hit(paddr, `CFEWL_OFF_FORCE)
                   & pwdata[`CFEWL_BIT_FUNCTION_INTERRUPT_FLAG];
  assign ev_set[0] = (wr & pstrb[0] & hit(paddr, `CFEWL_OFF_FORCE)
                   & pwdata[`CFEWL_BIT_GENERAL_WAKE_FLAG])
                   | (regs_on & ps.general_wake_flag & ~mst.general_wake_flag_prev);
  assign ev_clr[1] = wr & pstrb[1] & hit(paddr, `CFEWL_OFF_EVENT)
                   & pwdata[`CFEWL_BIT_FUNCTION_INTERRUPT_FLAG];
  assign ev_clr[0] = wr & pstrb[0] & hit(paddr, `CFEWL_OFF_EVENT)
                   & pwdata[`CFEWL_BIT_GENERAL_WAKE_FLAG];

  // Flags sit on the power-on reset only, so the card reset pin leaves them
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_flag
      logic f;
      cfewl_sticky u_flag (
        .pclk(pclk),
        .flag_rst_n(power_on_rst_n),
        .clk_en(clk_en),
        .set(ev_set[g]),
        .clear(ev_clr[g]),
        .flag(f)
      );
    end
  endgenerate
  assign ev.function_interrupt_flag = g_flag[1].f;
  assign ev.general_wake_flag = g_flag[0].f;

  always_comb
  begin
    rdata = 32'h0000_0000;
    if (regs_on)
    begin
      if (hit(paddr, `CFEWL_OFF_EVENT))
      begin
        rdata[`CFEWL_BIT_FUNCTION_INTERRUPT_FLAG] = ev.function_interrupt_flag;
        rdata[`CFEWL_BIT_GENERAL_WAKE_FLAG] = ev.general_wake_flag;
      end
      else if (hit(paddr, `CFEWL_OFF_MASK))
      begin
        rdata[`CFEWL_BIT_FUNCTION_INTERRUPT_FLAG] = mst.mask.function_interrupt_flag;
        rdata[`CFEWL_BIT_WAKE_MASTER_MASK] = mst.mask.wake_master_mask;
        rdata[`CFEWL_BIT_GENERAL_WAKE_FLAG] = mst.mask.general_wake_flag;
      end
      else if (hit(paddr, `CFEWL_OFF_STATE))
      begin
        rdata[`CFEWL_BIT_FUNCTION_INTERRUPT_FLAG] = ps.function_interrupt_flag;
        rdata[`CFEWL_BIT_GENERAL_WAKE_FLAG] = ps.general_wake_flag;
      end
    end
  end

  always_comb
  begin
    next_mst = mst;
    // Wake history on the power-on reset, so a card reset cannot fake an edge
    next_mst.general_wake_flag_prev = ps.general_wake_flag;
    if (wr && hit(paddr, `CFEWL_OFF_MASK))
    begin
      if (pstrb[1])
      begin
        next_mst.mask.function_interrupt_flag = pwdata[`CFEWL_BIT_FUNCTION_INTERRUPT_FLAG];
        next_mst.mask.wake_master_mask = pwdata[`CFEWL_BIT_WAKE_MASTER_MASK];
      end
      if (pstrb[0])
        next_mst.mask.general_wake_flag = pwdata[`CFEWL_BIT_GENERAL_WAKE_FLAG];
    end
  end

  // Masks survive the card reset pin
  always_ff @(posedge pclk or negedge power_on_rst_n)
  begin
    if (!power_on_rst_n)
      mst <= '0;
    else if (clk_en)
      mst <= next_mst;
  end

  always_comb
  begin
    logic function_interrupt_flag_src;
    logic wake_src;
    function_interrupt_flag_src = 1'b0;
    wake_src = 1'b0;
    next_st = st;
    // Data is registered in setup, so access completes in one cycle when clk_en is high in the setup cycle
    next_st.rsp.pready = psel & ~penable;
    next_st.rsp.pslverr = 1'b0;
    if (rd)
      next_st.rsp.prdata = rdata;
    function_interrupt_flag_src = regs_on & mst.mask.function_interrupt_flag & (ps.function_interrupt_flag | ev.function_interrupt_flag);
    wake_src = regs_on & mst.mask.wake_master_mask
             & ((mst.mask.function_interrupt_flag & ev.function_interrupt_flag)
             | (mst.mask.general_wake_flag & ev.general_wake_flag));
    next_st.int_n = ~(function_interrupt_flag_src & interface_powered);
    next_st.cstschg = wake_src & ~interface_powered;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.int_n <= 1'b1;
    end
    else if (clk_en)
      st <= next_st;
  end

  assign prdata = st.rsp.prdata;
  assign pready = st.rsp.pready;
  assign pslverr = st.rsp.pslverr;
  assign int_n = st.int_n;
  assign cstschg = st.cstschg;
endmodule

/* File: cfewl_defs.svh */
// Register offsets, field positions and reset values of the function event logic
`ifndef CFEWL_DEFS_SVH
`define CFEWL_DEFS_SVH
`define CFEWL_OFF_EVENT 8'hF0
`define CFEWL_OFF_MASK 8'hF4
`define CFEWL_OFF_STATE 8'hF8
`define CFEWL_OFF_FORCE 8'hFC
`define CFEWL_BIT_FUNCTION_INTERRUPT_FLAG 15
`define CFEWL_BIT_WAKE_MASTER_MASK 14
`define CFEWL_BIT_GENERAL_WAKE_FLAG 4
`define CFEWL_CFG3_CARD_EN 3
`define CFEWL_CFG3_FUNC_EN 1
`define CFEWL_ISR_W 16
`define CFEWL_RST_FLAG 1'b0
`endif

/* File: cfewl_pkg.sv */
// Types of the function event logic
package cfewl_pkg;
  typedef struct packed {
    logic function_interrupt_flag;
    logic general_wake_flag;
  } cfewl_flags_t;
  typedef struct packed {
    logic function_interrupt_flag;
    logic wake_master_mask;
    logic general_wake_flag;
  } cfewl_mask_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cfewl_apb_rsp_t;
endpackage

/* File: cfewl_sticky.sv */
// One sticky event flag: set wins over write-one-to-clear
module cfewl_sticky
  import cfewl_pkg::*;
(
  input wire logic pclk,
  input wire logic flag_rst_n,
  input wire logic clk_en,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } cfewl_sticky_state_t;
  cfewl_sticky_state_t st;
  cfewl_sticky_state_t next_st;
  always_comb
  begin
    next_st = st;
    if (set)
      next_st.flag = 1'b1;
    else if (clear)
      next_st.flag = 1'b0;
  end
  always_ff @(posedge pclk or negedge flag_rst_n)
  begin
    if (!flag_rst_n)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end
  assign flag = st.flag;
endmodule

/* File: cfewl_props.sv */
// Port assertions for the function event logic
module cfewl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] third_configuration_register,
  input wire logic interface_powered,
  input wire logic int_n,
  input wire logic cstschg
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rs = psel && !penable && !pwrite;
  wire logic en = third_configuration_register[3] && third_configuration_register[1];
  property p_rdy; clk_en && psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("late ready");
  property p_one; pready && clk_en |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; !pslverr; endproperty
  a_err: assert property (p_err) else $error("slave error");
  property p_rsv; pready && !pwrite |-> (prdata & 32'hFFFF3FEF) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_dis; clk_en && rs && !en |=> prdata == 32'h0; endproperty
  a_dis: assert property (p_dis) else $error("disabled read");
  property p_frc; clk_en && rs && paddr == 8'hFC |=> prdata == 32'h0; endproperty
  a_frc: assert property (p_frc) else $error("force read");
  property p_pwr; (clk_en && !interface_powered) [*3] |-> int_n; endproperty
  a_pwr: assert property (p_pwr) else $error("int while off");
  property p_off; (clk_en && interface_powered) [*3] |-> !cstschg; endproperty
  a_off: assert property (p_off) else $error("wake while on");
  property p_frz;
    !clk_en |=> $stable(int_n) && $stable(cstschg) && $stable(prdata);
  endproperty
  a_frz: assert property (p_frz) else $error("pins moved while frozen");
  property p_excl; !(!int_n && cstschg); endproperty
  a_excl: assert property (p_excl) else $error("both pins active");
  c_int: cover property (!int_n);
  c_wk: cover property (cstschg);
  c_fw: cover property (pready && pwrite && paddr == 8'hFC);
endmodule
bind cfewl_top cfewl_props cfewl_props_i (.*);

/* File: cfewl_host.sv */
// APB host model for the function event registers
module cfewl_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'hF,
  output logic tmo = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 9);
    r = prdata;
    tmo = !pready;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released write data bus shows no stale data
    pwdata <= ~d;
  endtask
endmodule

/* File: tb_card_function_event_wake_logic.sv */
// Self-checking bench for the function event logic
module tb_card_function_event_wake_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, power_on_rst_n = 1'b0, clk_en = 1'b1, pme_status = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, int_n, cstschg, tmo, interface_powered = 1'b1;
  logic [7:0] paddr, third_configuration_register = 8'h00;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [15:0] interrupt_status_register = 16'h0000;
  int failures = 0, n_compared = 0, mev = 0, mmk = 0;
  wire logic en = third_configuration_register[3] && third_configuration_register[1];
  cfewl_host host_i (.*);
  cfewl_top cfewl_top_i (.*);
  initial forever #2.5 pclk = ~pclk;
  task results();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task ck(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task x(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    host_i.xfer(w, a, d, s, r);
    if (tmo)
    begin
      failures++;
      results();
    end
  endtask
  task wr(input logic [7:0] a, input int d, input logic [3:0] s);
    int m;
    // Bits 15 and 14 ride on lane 1, bit 4 on lane 0
    m = (s[1] ? 32'hC000 : 32'h0) | (s[0] ? 32'h0010 : 32'h0);
    x(1'b1, a, d, s);
    if (en && a == 8'hF4) mmk = (mmk & ~m) | (d & m);
    if (en && a == 8'hF0) mev = mev & ~(d & m & 32'h8010);
    if (en && a == 8'hFC) mev = mev | (d & m & 32'h8010);
  endtask
  task rd(input logic [7:0] a);
    logic [31:0] e;
    e = a == 8'hF0 ? mev : a == 8'hF4 ? mmk : 32'h0;
    if (a == 8'hF8) e = {16'h0, |interrupt_status_register, 10'h0, pme_status, 4'h0};
    x(1'b0, a, 32'h0, 4'h0);
    ck("read", en ? e : 32'h0, r);
  endtask
  task pins();
    repeat (3) @(posedge pclk);
    ck("int_n", !(interface_powered && mmk[15] && (mev[15] || |interrupt_status_register)), int_n);
    ck("cstschg", !interface_powered && mmk[14] && (mmk[15] && mev[15] || mmk[4] && mev[4]), cstschg);
  endtask
  initial
  begin
    void'($urandom(80));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    power_on_rst_n <= 1'b1;
    wr(8'hF4, 32'hFFFF, 4'hF);
    rd(8'hF4);
    third_configuration_register <= 8'h0A;
    wr(8'hF4, $urandom, 4'hF);
    rd(8'hF4);
    $display("masks done");
    for (int i = 3; i >= 0; i--)
    begin
      wr(i[1] ? 8'hFC : 8'hF0, i[0] ? 32'h8000 : 32'hFFFFFFFF, 4'hF);
      rd(8'hF0);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(i[1] ? 8'hF0 : 8'hFC, 32'h8010, i[0] ? 4'h1 : 4'h2);
      rd(8'hF0);
    end
    $display("flags done");
    pme_status <= 1'b1;
    mev = mev | 32'h10;
    repeat (3) @(posedge pclk);
    rd(8'hF0);
    wr(8'hF4, 32'hC010, 4'hF);
    pins();
    interrupt_status_register <= 16'h0100;
    pins();
    rd(8'hF8);
    interrupt_status_register <= 16'h0000;
    wr(8'hF4, 32'h4010, 4'hF);
    pins();
    interface_powered <= 1'b0;
    pins();
    // Low clock enable must hold the wake pin through a power change
    clk_en <= 1'b0;
    interface_powered <= 1'b1;
    repeat (3) @(posedge pclk);
    ck("frozen cstschg", 32'h1, cstschg);
    clk_en <= 1'b1;
    pins();
    interface_powered <= 1'b0;
    wr(8'hF4, 32'h0010, 4'hF);
    pins();
    $display("pins done");
    // Wake flag cleared while wake status stays high: a card reset must not re-arm it
    wr(8'hFC, 32'h8000, 4'hF);
    wr(8'hF0, 32'h0010, 4'hF);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(8'hF4);
    rd(8'hF0);
    pins();
    $display("reset done");
    results();
  end
endmodule
